// File: src/fps_map.vh
// What this block does
// RL1: start on pick-up crossing, trip once it persists past the stage delay
// RL2: frequency from first two voltage channels, adapted value when none energized
// RL3: configurable stages compare over or under by their mode bit
// RL4: under-frequency stages blocked while largest line voltage is below limit
// RL5: after low voltage, stay blocked until frequency reaches the pick-up
// RL6: four stages, two configurable and two under-frequency only
// RL7: each stage has its own pick-up and own definite delay
// RL8: four setting groups, chosen manually or by a selected signal source
// RL9: each stage reports none, blocked, start or trip
// RL10: cumulative start and trip counters, clearable on request
// RL11: one shared force flag, cleared automatically after a timeout
// RL12: start and trip status writable only while force flag set
// RL13: settings accepted only after a valid password; operator supplies it first
// RL14: one low-voltage block limit in percent of nominal for all stages
// RL15: fault records hold date, millisecond time, frequency and group
// RL16: fault record holds elapsed delay percent, full value means tripped
// RL17: record store is circular, overwriting the oldest when full
// RL18: start released and timer reset on pick-up loss or block
`ifndef FPS_MAP_VH
`define FPS_MAP_VH

// timing
`define FPS_CLK_HZ          36'd50000000
`define FPS_TICK_MS         36'd1
`define FPS_MS_CYCLES       (`FPS_CLK_HZ * `FPS_TICK_MS / 36'd1000)
`define FPS_FORCE_TIMEOUT_S 36'd300
`define FPS_FORCE_CYCLES    (`FPS_FORCE_TIMEOUT_S * `FPS_CLK_HZ)

// register byte offsets
`define FPS_A_CTRL      8'h00
`define FPS_A_PASS      8'h04
`define FPS_A_LVLIM     8'h08
`define FPS_A_MODE      8'h0c
`define FPS_A_FSTAT     8'h10
`define FPS_A_CLR       8'h14
`define FPS_A_STATUS    8'h18
`define FPS_A_FREQ      8'h1c
`define FPS_A_RECSEL    8'h20
`define FPS_A_RDATE     8'h24
`define FPS_A_RTOD      8'h28
`define FPS_A_RINFO     8'h2c
`define FPS_A_PICK_HI   2'h1
`define FPS_A_DLY_HI    2'h2
`define FPS_A_CNT_HI    4'hc

// ctrl fields
`define FPS_CTRL_FORCE  0
`define FPS_CTRL_GRP_LO 2
`define FPS_CTRL_SRC_LO 4
`define FPS_CTRL_IDX_LO 7
`define FPS_CTRL_ALT_LO 10

// reset values, nominal frequency and full percent
`define FPS_RST_PICKUP  16'h1388
`define FPS_RST_DELAY   16'h03e8
`define FPS_RST_LVLIM   16'h01f4
`define FPS_NOM_FREQ    16'h1388
`define FPS_FULL_PCT    7'h64

// stage status codes
`define FPS_ST_NONE     2'h0
`define FPS_ST_BLOCKED  2'h1
`define FPS_ST_START    2'h2
`define FPS_ST_TRIP     2'h3

// group select sources
`define FPS_SRC_NONE    3'h0
`define FPS_SRC_DI      3'h1
`define FPS_SRC_VI      3'h2
`define FPS_SRC_VO      3'h3
`define FPS_SRC_LED     3'h4
`define FPS_SRC_FKEY    3'h5

`endif

// File: src/fps_stage.v
`timescale 1ns/1ps
`default_nettype none
module fps_stage
(
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        ms_tick,
   input  wire [15:0] freq,
   input  wire [15:0] pickup,
   input  wire [15:0] delay_ms,
   input  wire        over_mode,
   input  wire        low_volt,
   output wire        start,
   output wire        trip,
   output wire        blocked,
   output wire [15:0] elapsed
);

   reg        init_blk_reg;
   reg        start_reg;
   reg        trip_reg;
   reg [15:0] elapsed_reg;

   wire pick   = over_mode ? (freq > pickup) : (freq < pickup); // RL3
   wire uf_blk = ~over_mode & (low_volt | init_blk_reg); // RL4

   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         init_blk_reg <= 1'b0;
         start_reg    <= 1'b0;
         trip_reg     <= 1'b0;
         elapsed_reg  <= 16'h0000;
      end
      else
      begin
         if (low_volt)
            init_blk_reg <= 1'b1; // RL5
         else if (freq >= pickup)
            init_blk_reg <= 1'b0; // RL5
         if (~pick | uf_blk)
         begin
            start_reg   <= 1'b0; // RL18
            trip_reg    <= 1'b0;
            elapsed_reg <= 16'h0000; // RL18
         end
         else
         begin
            start_reg <= 1'b1; // RL1
            // timer stops at the delay, so a zero delay trips at once
            if (ms_tick & (elapsed_reg < delay_ms))
               elapsed_reg <= elapsed_reg + 16'h0001; // RL7
            if (elapsed_reg >= delay_ms)
               trip_reg <= 1'b1; // RL1
         end
      end
   end

   assign start   = start_reg;
   assign trip    = trip_reg;
   assign blocked = uf_blk;
   assign elapsed = elapsed_reg;

endmodule // fps_stage
`default_nettype wire

// File: src/fps_top.v
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fps_map.vh"
module fps_top
#(
   parameter [35:0] FORCE_CYCLES = `FPS_FORCE_CYCLES,
   parameter [15:0] UNLOCK_KEY   = 16'h1234
)
(
   input  wire        clk_sys,
   input  wire        rst,
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_we,
   input  wire        reg_re,
   output wire [31:0] reg_rdata,
   input  wire [15:0] freq_ch1,
   input  wire [15:0] freq_ch2,
   input  wire        energized_ch1,
   input  wire        energized_ch2,
   input  wire [15:0] volt_u12,
   input  wire [15:0] volt_u23,
   input  wire [15:0] volt_u31,
   input  wire [31:0] rtc_date,
   input  wire [31:0] rtc_time_ms,
   input  wire [7:0]  digital_input_source,
   input  wire [7:0]  virtual_input_source,
   input  wire [7:0]  virtual_output_source,
   input  wire [7:0]  indicator_signal_source,
   input  wire [7:0]  function_key_source,
   output wire [3:0]  stage_start,
   output wire [3:0]  stage_trip,
   output wire [3:0]  stage_blocked,
   output wire [1:0]  active_group_index,
   output wire        force_active
);

   localparam [35:0] MS_CYC  = `FPS_MS_CYCLES;
   localparam [15:0] MS_LAST = MS_CYC[15:0] - 16'h0001;

   function [15:0] umax;
      input [15:0] a;
      input [15:0] b;
      begin
         umax = (a > b) ? a : b;
      end
   endfunction

   function [6:0] pct;
      input [15:0] e;
      input [15:0] d;
      reg   [23:0] t;
      begin
         t = 24'h000000;
         if (d == 16'h0000)
            pct = `FPS_FULL_PCT;
         else
         begin
            t = ({8'h00, e} * 24'd100) / {8'h00, d};
            pct = (t > 24'd100) ? `FPS_FULL_PCT : t[6:0];
         end
      end
   endfunction

   function [1:0] stat;
      input b;
      input s;
      input t;
      begin
         if (t)
            stat = `FPS_ST_TRIP;
         else if (s)
            stat = `FPS_ST_START;
         else if (b)
            stat = `FPS_ST_BLOCKED;
         else
            stat = `FPS_ST_NONE;
      end
   endfunction

   // settings and state
   reg [15:0] pickup_mem [0:15];
   reg [15:0] delay_mem  [0:15];
   reg [15:0] start_cnt  [0:3];
   reg [15:0] trip_cnt   [0:3];
   reg [15:0] el_prev    [0:3];
   reg [31:0] rec_date   [0:7];
   reg [31:0] rec_tod    [0:7];
   reg [31:0] rec_info   [0:7];
   reg        unlocked_reg;
   reg        force_reg;
   reg [35:0] force_cnt_reg;
   reg [1:0]  manual_grp_reg;
   reg [1:0]  alt_grp_reg;
   reg [2:0]  group_select_source;
   reg [2:0]  src_idx_reg;
   reg [15:0] low_voltage_block_limit;
   reg [3:0]  mode_reg;
   reg [3:0]  fstart_reg;
   reg [3:0]  ftrip_reg;
   reg [3:0]  start_prev_reg;
   reg [3:0]  trip_prev_reg;
   reg [15:0] adapted_reg;
   reg [15:0] ms_cnt_reg;
   reg        ms_tick_reg;
   reg [2:0]  wr_ptr_reg;
   reg [3:0]  rec_cnt_reg;
   reg [2:0]  rec_sel_reg;
   reg [7:0]  di_meta_reg;
   reg [7:0]  di_sync_reg;
   reg [7:0]  fk_meta_reg;
   reg [7:0]  fk_sync_reg;
   reg [31:0] rdata_reg;
   reg [31:0] rdata_next;
   reg        sel_sig;
   reg        cap;
   reg [1:0]  cap_stage;
   integer    i;
   integer    j;

   wire [3:0]  nat_start;
   wire [3:0]  nat_trip;
   wire [3:0]  nat_blk;
   wire [15:0] elapsed [0:3];
   wire [3:0]  start_eff;
   wire [3:0]  trip_eff;

   // measured frequency, adapted when no channel is energized
   wire [15:0] freq_meas = energized_ch1 ? freq_ch1 :
                           energized_ch2 ? freq_ch2 : adapted_reg; // RL2
   wire [15:0] volt_max  = umax(volt_u12, umax(volt_u23, volt_u31));
   wire        low_volt  = volt_max < low_voltage_block_limit; // RL14

   always @*
   begin
      case (group_select_source)
         `FPS_SRC_DI:   sel_sig = di_sync_reg[src_idx_reg];
         `FPS_SRC_VI:   sel_sig = virtual_input_source[src_idx_reg];
         `FPS_SRC_VO:   sel_sig = virtual_output_source[src_idx_reg];
         `FPS_SRC_LED:  sel_sig = indicator_signal_source[src_idx_reg];
         `FPS_SRC_FKEY: sel_sig = fk_sync_reg[src_idx_reg];
         default:       sel_sig = 1'b0;
      endcase
   end

   wire [1:0] grp = sel_sig ? alt_grp_reg : manual_grp_reg; // RL8

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : stg
         fps_stage u_stage
         (
            .clk_sys   (clk_sys),
            .rst       (rst),
            .ms_tick   (ms_tick_reg),
            .freq      (freq_meas),
            .pickup    (pickup_mem[g * 4 + grp]), // RL7
            .delay_ms  (delay_mem[g * 4 + grp]),
            .over_mode (mode_reg[g]), // RL6
            .low_volt  (low_volt),
            .start     (nat_start[g]),
            .trip      (nat_trip[g]),
            .blocked   (nat_blk[g]),
            .elapsed   (elapsed[g])
         );
      end
   endgenerate

   assign start_eff = nat_start | ({4{force_reg}} & fstart_reg); // RL12
   assign trip_eff  = nat_trip | ({4{force_reg}} & ftrip_reg);

   // first stage ending in this cycle is recorded
   always @*
   begin
      cap       = 1'b0;
      cap_stage = 2'h0;
      for (j = 3; j >= 0; j = j - 1)
      begin
         if (start_prev_reg[j] & ~start_eff[j])
         begin
            cap       = 1'b1;
            cap_stage = j[1:0];
         end
      end
   end

   wire set_ok = reg_we & unlocked_reg; // RL13

   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         unlocked_reg            <= 1'b0;
         force_reg               <= 1'b0;
         force_cnt_reg           <= 36'h000000000;
         manual_grp_reg          <= 2'h0;
         alt_grp_reg             <= 2'h1;
         group_select_source     <= `FPS_SRC_NONE;
         src_idx_reg             <= 3'h0;
         low_voltage_block_limit <= `FPS_RST_LVLIM;
         mode_reg                <= 4'h0;
         fstart_reg              <= 4'h0;
         ftrip_reg               <= 4'h0;
         start_prev_reg          <= 4'h0;
         trip_prev_reg           <= 4'h0;
         adapted_reg             <= `FPS_NOM_FREQ;
         ms_cnt_reg              <= 16'h0000;
         ms_tick_reg             <= 1'b0;
         wr_ptr_reg              <= 3'h0;
         rec_cnt_reg             <= 4'h0;
         rec_sel_reg             <= 3'h0;
         di_meta_reg             <= 8'h00;
         di_sync_reg             <= 8'h00;
         fk_meta_reg             <= 8'h00;
         fk_sync_reg             <= 8'h00;
         for (i = 0; i < 16; i = i + 1)
         begin
            pickup_mem[i] <= `FPS_RST_PICKUP;
            delay_mem[i]  <= `FPS_RST_DELAY;
         end
         for (i = 0; i < 4; i = i + 1)
         begin
            start_cnt[i] <= 16'h0000;
            trip_cnt[i]  <= 16'h0000;
            el_prev[i]   <= 16'h0000;
         end
         for (i = 0; i < 8; i = i + 1)
         begin
            rec_date[i] <= 32'h00000000;
            rec_tod[i]  <= 32'h00000000;
            rec_info[i] <= 32'h00000000;
         end
      end
      else
      begin
         di_meta_reg <= digital_input_source;
         di_sync_reg <= di_meta_reg;
         fk_meta_reg <= function_key_source;
         fk_sync_reg <= fk_meta_reg;
         if (energized_ch1 | energized_ch2)
            adapted_reg <= freq_meas; // RL2
         ms_tick_reg <= (ms_cnt_reg == MS_LAST);
         ms_cnt_reg  <= (ms_cnt_reg == MS_LAST) ? 16'h0000 : ms_cnt_reg + 16'h0001;
         start_prev_reg <= start_eff;
         trip_prev_reg  <= trip_eff;
         // force timeout, a setting write in the same cycle wins
         if (force_reg)
            force_cnt_reg <= force_cnt_reg + 36'h000000001;
         if (force_reg & (force_cnt_reg >= FORCE_CYCLES - 36'h000000001))
         begin
            force_reg     <= 1'b0; // RL11
            force_cnt_reg <= 36'h000000000;
         end
         // counter clear first, so a same-cycle event wins
         if (reg_we & (reg_addr == `FPS_A_CLR))
         begin
            for (i = 0; i < 4; i = i + 1)
            begin
               if (reg_wdata[i])
                  start_cnt[i] <= 16'h0000; // RL10
               if (reg_wdata[i + 4])
                  trip_cnt[i] <= 16'h0000; // RL10
            end
         end
         for (i = 0; i < 4; i = i + 1)
         begin
            el_prev[i] <= elapsed[i];
            if (start_eff[i] & ~start_prev_reg[i])
               start_cnt[i] <= start_cnt[i] + 16'h0001; // RL10
            if (trip_eff[i] & ~trip_prev_reg[i])
               trip_cnt[i] <= trip_cnt[i] + 16'h0001; // RL10
         end
         if (cap)
         begin
            rec_date[wr_ptr_reg] <= rtc_date; // RL15
            rec_tod[wr_ptr_reg]  <= rtc_time_ms;
            rec_info[wr_ptr_reg] <= {freq_meas,
                                     trip_prev_reg[cap_stage] ? `FPS_FULL_PCT :
                                     pct(el_prev[cap_stage],
                                         delay_mem[{cap_stage, grp}]), // RL16
                                     grp, cap_stage, 5'h00};
            wr_ptr_reg <= wr_ptr_reg + 3'h1; // RL17
            if (rec_cnt_reg != 4'h8)
               rec_cnt_reg <= rec_cnt_reg + 4'h1;
         end
         if (reg_we & (reg_addr == `FPS_A_PASS))
            unlocked_reg <= (reg_wdata[15:0] == UNLOCK_KEY); // RL13
         if (reg_we & (reg_addr == `FPS_A_RECSEL))
            rec_sel_reg <= reg_wdata[2:0];
         if (reg_we & (reg_addr == `FPS_A_FSTAT) & force_reg)
         begin
            fstart_reg <= reg_wdata[3:0]; // RL12
            ftrip_reg  <= reg_wdata[7:4];
         end
         if (~force_reg)
         begin
            fstart_reg <= 4'h0;
            ftrip_reg  <= 4'h0;
         end
         if (set_ok)
         begin
            if (reg_addr == `FPS_A_CTRL)
            begin
               force_reg           <= reg_wdata[`FPS_CTRL_FORCE]; // RL11
               force_cnt_reg       <= 36'h000000000;
               manual_grp_reg      <= reg_wdata[`FPS_CTRL_GRP_LO +: 2];
               group_select_source <= reg_wdata[`FPS_CTRL_SRC_LO +: 3];
               src_idx_reg         <= reg_wdata[`FPS_CTRL_IDX_LO +: 3];
               alt_grp_reg         <= reg_wdata[`FPS_CTRL_ALT_LO +: 2];
            end
            else if (reg_addr == `FPS_A_LVLIM)
               low_voltage_block_limit <= reg_wdata[15:0]; // RL14
            else if (reg_addr == `FPS_A_MODE)
               mode_reg <= {2'h0, reg_wdata[1:0]}; // RL6
            else if (reg_addr[7:6] == `FPS_A_PICK_HI)
               pickup_mem[reg_addr[5:2]] <= reg_wdata[15:0]; // RL7
            else if (reg_addr[7:6] == `FPS_A_DLY_HI)
               delay_mem[reg_addr[5:2]] <= reg_wdata[15:0]; // RL7
         end
      end
   end

   // read path, data valid the cycle after the strobe
   always @*
   begin
      rdata_next = 32'h00000000;
      if (reg_addr == `FPS_A_CTRL)
         rdata_next = {20'h00000, alt_grp_reg, src_idx_reg, group_select_source,
                       manual_grp_reg, 1'b0, force_reg};
      else if (reg_addr == `FPS_A_PASS)
         rdata_next = {31'h00000000, unlocked_reg};
      else if (reg_addr == `FPS_A_LVLIM)
         rdata_next = {16'h0000, low_voltage_block_limit};
      else if (reg_addr == `FPS_A_MODE)
         rdata_next = {28'h0000000, mode_reg};
      else if (reg_addr == `FPS_A_FSTAT)
         rdata_next = {24'h000000, ftrip_reg, fstart_reg};
      else if (reg_addr == `FPS_A_STATUS)
         rdata_next = {20'h00000, unlocked_reg, force_reg, grp,
                       stat(nat_blk[3], start_eff[3], trip_eff[3]),
                       stat(nat_blk[2], start_eff[2], trip_eff[2]),
                       stat(nat_blk[1], start_eff[1], trip_eff[1]),
                       stat(nat_blk[0], start_eff[0], trip_eff[0])}; // RL9
      else if (reg_addr == `FPS_A_FREQ)
         rdata_next = {16'h0000, freq_meas};
      else if (reg_addr == `FPS_A_RECSEL)
         rdata_next = {21'h000000, rec_cnt_reg, 1'b0, wr_ptr_reg, rec_sel_reg};
      else if (reg_addr == `FPS_A_RDATE)
         rdata_next = rec_date[rec_sel_reg];
      else if (reg_addr == `FPS_A_RTOD)
         rdata_next = rec_tod[rec_sel_reg];
      else if (reg_addr == `FPS_A_RINFO)
         rdata_next = rec_info[rec_sel_reg];
      else if (reg_addr[7:6] == `FPS_A_PICK_HI)
         rdata_next = {16'h0000, pickup_mem[reg_addr[5:2]]};
      else if (reg_addr[7:6] == `FPS_A_DLY_HI)
         rdata_next = {16'h0000, delay_mem[reg_addr[5:2]]};
      else if (reg_addr[7:4] == `FPS_A_CNT_HI)
         rdata_next = {trip_cnt[reg_addr[3:2]], start_cnt[reg_addr[3:2]]};
   end

   always @(posedge clk_sys)
   begin
      if (rst)
         rdata_reg <= 32'h00000000;
      else if (reg_re)
         rdata_reg <= rdata_next;
      else
         rdata_reg <= 32'h00000000;
   end

   assign reg_rdata          = rdata_reg;
   assign stage_start        = start_eff;
   assign stage_trip         = trip_eff;
   assign stage_blocked      = nat_blk;
   assign active_group_index = grp;
   assign force_active       = force_reg;

endmodule // fps_top
`default_nettype wire

// File: testbench/fps_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fps_chk
#(
   parameter [35:0] FORCE_CYCLES = 36'd200
)
(
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_we,
   input wire logic        reg_re,
   input wire logic [31:0] reg_rdata,
   input wire logic [15:0] freq_ch1,
   input wire logic        energized_ch1,
   input wire logic        energized_ch2,
   input wire logic [3:0]  stage_start,
   input wire logic [3:0]  stage_trip,
   input wire logic [3:0]  stage_blocked,
   input wire logic [1:0]  active_group_index,
   input wire logic        force_active
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   logic [35:0] frc_cnt;
   // cycles of force since its last control write
   always @(posedge clk_sys)
   begin
      if (rst || !force_active || (reg_we && reg_addr == 8'h00))
         frc_cnt <= 36'h0;
      else
         frc_cnt <= frc_cnt + 36'h1;
   end
   sequence ch1_steady;
      (energized_ch1 && !energized_ch2 && $stable(freq_ch1)) [*4];
   endsequence
   sequence freq_read;
      reg_re && reg_addr == 8'h1c;
   endsequence
   reset_vals_a: assert property ($past(rst) |-> stage_start == 4'h0 &&
      stage_trip == 4'h0 && !force_active && active_group_index == 2'h0)
      else $error("outputs not clear after reset");
   idle_rdata_a: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   unmapped_rd_a: assert property (reg_re && reg_addr >= 8'hd0 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   pass_rd_a: assert property (reg_re && reg_addr == 8'h04 |=> reg_rdata[31:1] == 31'h0)
      else $error("unlock read has extra bits");
   status_grp_a: assert property (reg_re && reg_addr == 8'h18 |=>
      reg_rdata[10:8] == {$past(force_active), $past(active_group_index)})
      else $error("status group or force wrong");
   status_trip_a: assert property (reg_re && reg_addr == 8'h18 && stage_trip[0]
      |=> reg_rdata[1:0] == 2'h3) else $error("status code not trip");
   force_rise_a: assert property ($rose(force_active) |->
      $past(reg_we && reg_addr == 8'h00 && reg_wdata[0])) else $error("force without write");
   force_tout_a: assert property (force_active |-> frc_cnt <= FORCE_CYCLES + 36'h1)
      else $error("force outlived timeout");
   blk_start_a: assert property (!force_active && !$past(force_active) |->
      (stage_start & $past(stage_blocked)) == 4'h0) else $error("start while blocked");
   freq_rd_a: assert property (ch1_steady ##0 freq_read |=>
      reg_rdata[15:0] == $past(freq_ch1)) else $error("measured frequency wrong");
endmodule // fps_chk
bind fps_top fps_chk #(.FORCE_CYCLES(FORCE_CYCLES)) u_chk
(
   .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .freq_ch1,
   .energized_ch1, .energized_ch2, .stage_start, .stage_trip, .stage_blocked,
   .active_group_index, .force_active
);
`default_nettype wire

// File: testbench/fps_front.sv
`timescale 1ns/1ps
`default_nettype none
module fps_front
(
   input  wire logic        clk_sys,
   output wire logic [15:0] freq_ch1,
   output wire logic [15:0] freq_ch2,
   output wire logic        energized_ch1,
   output wire logic        energized_ch2,
   output wire logic [15:0] volt_u12,
   output wire logic [15:0] volt_u23,
   output wire logic [15:0] volt_u31
);
   logic [15:0] f_reg = 16'h1388;
   logic [15:0] v_reg = 16'h03e8;
   logic [1:0]  en_reg = 2'h3;
   logic [1:0]  en_q = 2'h3;
   logic [15:0] q1_reg = 16'h1388;
   logic [15:0] q2_reg = 16'h1388;
   // dead channel shows a changing pattern, not its last value
   always @(posedge clk_sys)
   begin
      en_q <= en_reg;
      q1_reg <= en_reg[0] ? f_reg : ~q1_reg;
      q2_reg <= en_reg[1] ? f_reg : ~q2_reg;
   end
   assign freq_ch1 = q1_reg;
   assign freq_ch2 = q2_reg;
   assign energized_ch1 = en_q[0];
   assign energized_ch2 = en_q[1];
   // largest line voltage sits on the middle pair
   assign volt_u12 = v_reg >> 1;
   assign volt_u23 = v_reg;
   assign volt_u31 = v_reg >> 2;
   task drive(input logic [15:0] f, input logic [15:0] v, input logic [1:0] en);
      @(posedge clk_sys);
      f_reg <= f;
      v_reg <= v;
      en_reg <= en;
   endtask
endmodule // fps_front
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_we = 1'b0;
   logic        reg_re = 1'b0;
   logic [7:0]  src = 8'h00;
   logic [31:0] rtc_time_ms = 32'h0;
   logic [31:0] rdata_q;
   logic [31:0] tcap;
   wire  [31:0] reg_rdata;
   wire  [15:0] freq_ch1, freq_ch2, volt_u12, volt_u23, volt_u31;
   wire         energized_ch1, energized_ch2, force_active;
   wire  [3:0]  stage_start, stage_trip, stage_blocked;
   wire  [1:0]  active_group_index;
   int          n_fail = 0;
   int          cmp_count = 0;
   fps_top #(.FORCE_CYCLES(36'd200)) dut
   (
      .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
      .freq_ch1, .freq_ch2, .energized_ch1, .energized_ch2, .volt_u12, .volt_u23,
      .volt_u31, .rtc_date(32'h00000a0b), .rtc_time_ms, .digital_input_source(src),
      .virtual_input_source(src), .virtual_output_source(src),
      .indicator_signal_source(src), .function_key_source(src), .stage_start,
      .stage_trip, .stage_blocked, .active_group_index, .force_active
   );
   fps_front fe
   (
      .clk_sys, .freq_ch1, .freq_ch2, .energized_ch1, .energized_ch2, .volt_u12,
      .volt_u23, .volt_u31
   );
   initial
   begin
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) rtc_time_ms <= rtc_time_ms + 32'h1;
   task chk(input logic [31:0] got, input logic [31:0] e);
      cmp_count++;
      if (got !== e)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h exp %h", $time, got, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_we <= 1'b1;
      @(posedge clk_sys);
      reg_we <= 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk_sys);
      reg_re <= 1'b0;
      @(negedge clk_sys);
      rdata_q = reg_rdata;
      chk(rdata_q, e);
   endtask
   task wt(input logic [3:0] es, input logic [3:0] et);
      int k;
      k = 0;
      while ((stage_start !== es || stage_trip !== et) && k < 12)
      begin
         @(negedge clk_sys);
         k++;
      end
      chk(stage_start, es);
      chk(stage_trip, et);
   endtask
   task t_reset;
      @(negedge clk_sys);
      chk({stage_start, stage_trip, stage_blocked, active_group_index, force_active}, 0);
      rdc(8'h40, 32'h1388);
      rdc(8'h80, 32'h3e8);
      rdc(8'h08, 32'h1f4);
      rdc(8'hf0, 32'h0);
      $display("done reset");
   endtask
   task t_lock;
      wr(8'h08, 32'h100);
      rdc(8'h08, 32'h1f4);
      wr(8'h04, 32'h4321);
      rdc(8'h04, 32'h0);
      wr(8'h04, 32'h1234);
      rdc(8'h04, 32'h1);
      for (int i = 0; i < 16; i++)
         wr(8'h80 + 8'(4 * i), 32'h0);
      rdc(8'hbc, 32'h0);
      $display("done lock");
   endtask
   task t_under;
      fe.drive(16'h1300, 16'h3e8, 2'h2);
      wt(4'hf, 4'hf);
      rdc(8'h1c, 32'h1300);
      rdc(8'h18, 32'h8ff);
      rdc(8'hc0, 32'h10001);
      fe.drive(16'h1388, 16'h3e8, 2'h3);
      wt(4'h0, 4'h0);
      tcap = rtc_time_ms;
      wr(8'h20, 32'h0);
      rdc(8'h20, 32'h88);
      rdc(8'h24, 32'h0a0b);
      rdc(8'h28, tcap);
      rdc(8'h2c, 32'h1388c800);
      wr(8'h14, 32'hff);
      rdc(8'hc0, 32'h0);
      $display("done under");
   endtask
   task t_mode;
      wr(8'h0c, 32'h3);
      fe.drive(16'h1400, 16'h3e8, 2'h1);
      wt(4'h3, 4'h3);
      repeat (2) @(negedge clk_sys);
      rdc(8'h1c, 32'h1400);
      fe.drive(16'h1300, 16'h3e8, 2'h3);
      wt(4'hc, 4'hc);
      fe.drive(16'h1388, 16'h3e8, 2'h3);
      wt(4'h0, 4'h0);
      wr(8'h0c, 32'h0);
      $display("done mode");
   endtask
   task t_lowv;
      fe.drive(16'h1388, 16'h100, 2'h3);
      repeat (3) @(negedge clk_sys);
      chk(stage_blocked, 4'hf);
      fe.drive(16'h1300, 16'h100, 2'h3);
      repeat (4) @(negedge clk_sys);
      chk(stage_start, 4'h0);
      fe.drive(16'h1300, 16'h3e8, 2'h3);
      repeat (4) @(negedge clk_sys);
      chk({stage_blocked, stage_start}, 8'hf0);
      fe.drive(16'h1388, 16'h3e8, 2'h3);
      repeat (3) @(negedge clk_sys);
      chk(stage_blocked, 4'h0);
      fe.drive(16'h1300, 16'h3e8, 2'h3);
      wt(4'hf, 4'hf);
      fe.drive(16'h1388, 16'h3e8, 2'h3);
      wt(4'h0, 4'h0);
      wr(8'h08, 32'h80);
      fe.drive(16'h1388, 16'h100, 2'h3);
      repeat (3) @(negedge clk_sys);
      chk(stage_blocked, 4'h0);
      fe.drive(16'h1388, 16'h3e8, 2'h3);
      wr(8'h08, 32'h1f4);
      $display("done lowv");
   endtask
   task t_ring;
      repeat (6)
      begin
         fe.drive(16'h1300, 16'h3e8, 2'h3);
         wt(4'hf, 4'hf);
         fe.drive(16'h1388, 16'h3e8, 2'h3);
         wt(4'h0, 4'h0);
      end
      rdc(8'h20, 32'h410);
      $display("done ring");
   endtask
   task t_group;
      for (int c = 1; c < 6; c++)
      begin
         wr(8'h00, 32'h588 | (32'(c) << 4));
         src <= 8'h08;
         repeat (5) @(negedge clk_sys);
         chk(active_group_index, 2'h1);
         @(posedge clk_sys);
         src <= 8'h00;
         repeat (5) @(negedge clk_sys);
         chk(active_group_index, 2'h2);
      end
      $display("done group");
   endtask
   task t_force;
      int k;
      wr(8'h10, 32'h0f);
      repeat (2) @(negedge clk_sys);
      chk(stage_start, 4'h0);
      wr(8'h00, 32'h1);
      @(negedge clk_sys);
      chk(force_active, 1'b1);
      wr(8'h10, 32'hf0);
      @(negedge clk_sys);
      chk(stage_trip, 4'hf);
      k = 4;
      while (force_active === 1'b1 && k < 400)
      begin
         @(negedge clk_sys);
         k++;
      end
      chk(32'(k > 190 && k < 210), 32'h1);
      chk(stage_trip, 4'h0);
      $display("done force");
   endtask
   task finish_test;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #400000;
      n_fail++;
      finish_test;
   end
   initial
   begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset;
      t_lock;
      t_under;
      t_mode;
      t_lowv;
      t_ring;
      t_group;
      t_force;
      finish_test;
   end
endmodule // tb
`default_nettype wire
